// File: hw/sfpm_pkg.sv
// shared constants, types and helpers for the serial flash power mode block
// assumes a 50 ns system clock; the link clock is whatever the host drives
package sfpm_pkg;

    // system clock period in ns (20 MHz)
    localparam int unsigned CLK_NS = 50;

    // default times, in ns, for the power transitions
    localparam int unsigned LOCKOUT_DEF_NS = 1000000; // powerup_write_lockout, 1 ms
    localparam int unsigned SLEEP_ENTRY_DEF_NS = 3000;
    localparam int unsigned EARLY_WAKE_DEF_NS = 3000;
    localparam int unsigned WAKE_DEF_NS = 1800;

    // frame bit positions, counted in rising link clock edges
    localparam logic [5:0] OPC_BITS = 6'h08;  // opcode is complete after 8 bits
    localparam logic [5:0] SIG_START = 6'h20; // opcode plus 3 dummy bytes
    localparam logic [5:0] SIG_LAST = 6'h27;  // last edge of one signature pass

    // status byte layout and delivered contents
    localparam int unsigned BUSY_BIT = 0;
    localparam int unsigned LATCH_BIT = 1;
    localparam logic [7:0] STATUS_INIT = 8'h00;
    localparam logic [7:0] MEM_ERASED = 8'hff;

    localparam int unsigned TIMER_W = 24;

    // power states, one-hot
    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_ENTERING = 4'h2,
        ST_SLEEP = 4'h4,
        ST_WAKING = 4'h8
    } sfpm_state_e;

    // what the link side saw in the last frame
    typedef struct packed {
        logic [7:0] op;
        logic [5:0] cnt;
        logic full;
    } sfpm_frame_s;

    // least time: round up, never below one cycle
    function automatic int unsigned sfpm_cyc_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down, never below one cycle
    function automatic int unsigned sfpm_cyc_dn(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

endpackage

// File: hw/sfpm_sync.sv
// two flip-flop level synchroniser
// assumes the input is a level that stays put for at least two destination edges
`timescale 1ns/1ps
module sfpm_sync (
    // destination clock
    input wire logic clk,
    // level in and synchronised level out
    input wire logic d,
    output logic q
);

    logic meta;

    // the first stage feeds only the second; no reset so no path from reset into meta
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end

endmodule

// File: hw/sfpm_power_ctl.sv
// power mode control of a serial flash: deep sleep, wake with signature, power-up lockout
// assumes nrst is the supply-threshold reset, spi_clk only runs while cs_n is low,
// and busy_in / write_latch_in come from the program engine on clk
//
// Contract
// - deep sleep entered only by deep_power_down opcode
// - chip select high gives standby when idle
// - supply loss clears sleep, start in standby
// - deep_power_down executes only with exactly eight bits
// - sleep entered after sleep_entry_delay
// - deep_power_down rejected while busy
// - signature returned whenever not busy
// - wake opcode ignored while busy
// - three dummy bytes, signature out on falling
// - signature repeats while chip select stays low
// - full signature: wake after wake_delay
// - partial signature: wake after early_wake_delay
// - held in reset below inhibit threshold
// - write commands ignored during power-up lockout
// - reads accepted during lockout
// - power-up: standby, flags cleared
// - delivered memory FFh, status 00h
// - busy flag follows self-timed cycle
`timescale 1ns/1ps
module sfpm_power_ctl import sfpm_pkg::*; #(
    parameter int unsigned LOCKOUT_NS = LOCKOUT_DEF_NS,
    parameter int unsigned SLEEP_ENTRY_NS = SLEEP_ENTRY_DEF_NS,
    parameter int unsigned EARLY_WAKE_NS = EARLY_WAKE_DEF_NS,
    parameter int unsigned WAKE_NS = WAKE_DEF_NS,
    parameter logic [7:0] SIGNATURE = 8'h5a, // arbitrary value
    parameter logic [7:0] OP_SLEEP = 8'hd1,
    parameter logic [7:0] OP_WAKE = 8'hd2,
    parameter logic [7:0] OP_WRITE_ENABLE_CMD = 8'hd3,
    parameter logic [7:0] OP_PROG = 8'hd4,
    parameter logic [7:0] OP_BLOCK_WIPE = 8'hd5,
    parameter logic [7:0] OP_FULL_WIPE = 8'hd6,
    parameter logic [7:0] OP_STATUS_WRITE = 8'hd7
) (
    // system clock and supply-threshold reset
    input wire logic clk,
    input wire logic nrst,
    // spi link pins
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe_n,
    // program engine status
    input wire logic busy_in,
    input wire logic write_latch_in,
    // power and command status
    output logic deep_sleep,
    output logic standby,
    output logic write_cmd_grant,
    output logic read_cmd_grant,
    output logic [7:0] status_byte,
    output logic [7:0] erased_byte
);

    // delays as clock counts, derived from the times
    localparam int unsigned LOCK_CYC = sfpm_cyc_up(LOCKOUT_NS);
    localparam int unsigned ENTRY_CYC = sfpm_cyc_up(SLEEP_ENTRY_NS);
    localparam int unsigned EARLY_CYC = sfpm_cyc_dn(EARLY_WAKE_NS);
    localparam int unsigned WAKE_CYC = sfpm_cyc_dn(WAKE_NS);
    localparam logic [TIMER_W-1:0] LOCK_END = TIMER_W'(LOCK_CYC);
    localparam logic [TIMER_W-1:0] ENTRY_LOAD = TIMER_W'(ENTRY_CYC - 1);
    localparam logic [TIMER_W-1:0] EARLY_LOAD = TIMER_W'(EARLY_CYC - 1);
    localparam logic [TIMER_W-1:0] WAKE_LOAD = TIMER_W'(WAKE_CYC - 1);

    // link domain state
    logic [5:0] bit_cnt;
    logic sig_full;
    logic [5:0] next_cnt;
    logic next_full;
    sfpm_frame_s snap;
    sfpm_frame_s next_snap;
    logic busy_link;
    logic next_miso;
    logic next_oe_n;

    // busy seen from the link side, to decide whether the signature is served
    sfpm_sync u_busy_sync (
        .clk(spi_clk),
        .d(busy_in),
        .q(busy_link)
    );

    // bit counter: opcode, three dummy bytes, then signature passes that wrap
    always_comb begin
        next_cnt = bit_cnt + 6'h01;
        next_full = sig_full;
        if (bit_cnt == SIG_LAST) begin
            next_cnt = SIG_START;
            next_full = 1'b1;
        end
        next_snap.cnt = next_cnt;
        next_snap.full = next_full;
        next_snap.op = snap.op;
        if (bit_cnt < OPC_BITS) begin
            next_snap.op = {snap.op[6:0], mosi}; // sampled on rising edges
        end
    end

    // chip select high clears the frame counters without needing a link edge
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt <= 6'h00;
            sig_full <= 1'b0;
        end else begin
            bit_cnt <= next_cnt;
            sig_full <= next_full;
        end
    end

    // frame summary, stable once the link clock stops; read on synchronised cs rise
    always_ff @(posedge spi_clk) begin
        snap <= next_snap;
    end

    // signature bit for the next falling edge; msb first
    always_comb begin
        next_miso = 1'b0;
        next_oe_n = 1'b1;
        if (bit_cnt >= SIG_START && snap.op == OP_WAKE && !busy_link) begin
            next_miso = SIGNATURE[3'(SIG_LAST - bit_cnt)];
            next_oe_n = 1'b0;
        end
    end

    // output launched on falling edges, released as soon as chip select rises
    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            miso_out <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            miso_out <= next_miso;
            miso_oe_n <= next_oe_n;
        end
    end

    // system domain state
    logic cs_sys;
    logic cs_prev;
    logic cs_rise;
    sfpm_state_e state;
    sfpm_state_e next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [TIMER_W-1:0] lock_cnt;
    logic [TIMER_W-1:0] next_lock;
    logic lockout_done;
    logic opcode_done;
    logic exact_opcode;
    logic is_write;
    logic next_wgrant;
    logic next_rgrant;
    logic next_deep;
    logic next_standby;
    logic [7:0] next_status;

    sfpm_sync u_cs_sync (
        .clk(clk),
        .d(cs_n),
        .q(cs_sys)
    );

    // frame decode from the summary left by the link side
    assign cs_rise = cs_sys & ~cs_prev;
    assign lockout_done = (lock_cnt == LOCK_END);
    assign opcode_done = (snap.cnt >= OPC_BITS) | snap.full;
    assign exact_opcode = (snap.cnt == OPC_BITS) & ~snap.full;
    assign is_write = (snap.op == OP_WRITE_ENABLE_CMD) | (snap.op == OP_PROG) |
        (snap.op == OP_BLOCK_WIPE) | (snap.op == OP_FULL_WIPE) |
        (snap.op == OP_STATUS_WRITE);

    // power state machine and command gating
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_wgrant = 1'b0;
        next_rgrant = 1'b0;
        next_lock = lockout_done ? lock_cnt : lock_cnt + 24'h000001;
        case (state)
            ST_STANDBY: begin
                if (cs_rise && opcode_done && !busy_in) begin
                    if (snap.op == OP_SLEEP) begin
                        if (exact_opcode) begin
                            next_state = ST_ENTERING;
                            next_timer = ENTRY_LOAD;
                        end
                    end else if (is_write) begin
                        next_wgrant = lockout_done;
                    end else if (snap.op != OP_WAKE) begin
                        next_rgrant = 1'b1;
                    end
                end
            end
            ST_ENTERING: begin
                if (timer == '0) begin
                    next_state = ST_SLEEP;
                end else begin
                    next_timer = timer - 24'h000001;
                end
            end
            ST_SLEEP: begin
                // everything but the wake opcode is dropped here
                if (cs_rise && opcode_done && !busy_in && snap.op == OP_WAKE) begin
                    next_state = ST_WAKING;
                    next_timer = snap.full ? WAKE_LOAD : EARLY_LOAD;
                end
            end
            ST_WAKING: begin
                if (timer == '0) begin
                    next_state = ST_STANDBY;
                end else begin
                    next_timer = timer - 24'h000001;
                end
            end
            default: begin
                next_state = ST_STANDBY;
                next_timer = '0;
            end
        endcase
        next_deep = (next_state == ST_SLEEP) | (next_state == ST_WAKING);
        next_standby = (next_state == ST_STANDBY) & cs_sys & ~busy_in;
        next_status = STATUS_INIT;
        next_status[BUSY_BIT] = busy_in;
        next_status[LATCH_BIT] = write_latch_in;
    end

    // registers; reset is the supply threshold, so sleep never survives it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_STANDBY;
            timer <= '0;
            lock_cnt <= '0;
            cs_prev <= 1'b1;
            write_cmd_grant <= 1'b0;
            read_cmd_grant <= 1'b0;
            deep_sleep <= 1'b0;
            standby <= 1'b0;
            status_byte <= STATUS_INIT;
        end else begin
            state <= next_state;
            timer <= next_timer;
            lock_cnt <= next_lock;
            cs_prev <= cs_sys;
            write_cmd_grant <= next_wgrant;
            read_cmd_grant <= next_rgrant;
            deep_sleep <= next_deep;
            standby <= next_standby;
            status_byte <= next_status;
        end
    end

    // the array holds no data here; report its delivered contents
    assign erased_byte = MEM_ERASED;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_sleep_entry_cause: assert property (
        $rose(state == ST_ENTERING) |-> $past(cs_rise) && $past(snap.op) == OP_SLEEP)
        else $error("sleep entry without a sleep opcode");
    a_dp_exact_len: assert property (
        state == ST_STANDBY && cs_rise && !exact_opcode |=> state != ST_ENTERING)
        else $error("sleep entered on a bad frame length");
    a_dp_busy_reject: assert property (
        state == ST_STANDBY && cs_rise && busy_in |=> state == ST_STANDBY)
        else $error("command taken while busy");
    a_entry_delay: assert property (
        state == ST_ENTERING && timer == '0 |=> state == ST_SLEEP ##1 deep_sleep)
        else $error("sleep not entered when the delay ran out");
    a_sleep_no_write: assert property (
        deep_sleep |-> !write_cmd_grant && !read_cmd_grant)
        else $error("command granted while asleep");
    a_lockout_hold: assert property (
        !lockout_done |-> ##1 !write_cmd_grant)
        else $error("write granted during power-up lockout");
    a_wake_delay: assert property (
        state == ST_SLEEP && cs_rise && !busy_in && opcode_done && snap.op == OP_WAKE
        |=> state == ST_WAKING && timer == (snap.full ? WAKE_LOAD : EARLY_LOAD))
        else $error("wake delay not loaded");
    a_wake_end: assert property (
        state == ST_WAKING && timer == '0 |=> state == ST_STANDBY && !deep_sleep)
        else $error("standby not reached when the wake delay ran out");
    a_power_up: assert property (
        $rose(nrst) |-> state == ST_STANDBY && !deep_sleep && status_byte == STATUS_INIT)
        else $error("bad state after power-up");
    a_busy_status: assert property (
        busy_in |=> status_byte[BUSY_BIT])
        else $error("busy flag not shown");

    c_enter_sleep: cover property (state == ST_ENTERING ##1 state == ST_SLEEP);
    c_full_wake: cover property (state == ST_SLEEP ##1 state == ST_WAKING && snap.full);
    c_early_wake: cover property (state == ST_SLEEP ##1 state == ST_WAKING && !snap.full);
    c_write_grant: cover property (write_cmd_grant);

endmodule

// File: testbench/sfpm_host_model.sv
// host spi controller model: one frame per rising go, mode 0, 12 ns link clock
// assumes the bench holds go high until ready rises and gives 7..63 edges
`timescale 1ns/1ps
module sfpm_host_model (
    // frame request from the bench
    input wire logic go,
    input wire logic [7:0] op,
    input wire logic [5:0] edges,
    output logic ready,
    // spi pins
    output logic cs_n,
    output logic spi_clk,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    // bits sampled after the dummy bytes, and whether the device drove at all
    output logic [15:0] rx,
    output logic seen_drive
);
    initial begin
        cs_n = 1'b1;
        spi_clk = 1'b0;
        mosi = 1'b0;
        ready = 1'b0;
        rx = 16'h0000;
        seen_drive = 1'b0;
    end

    // one frame; the link clock only runs while selected
    always @(posedge go) begin
        rx = 16'h0000;
        seen_drive = 1'b0;
        cs_n = 1'b0; // asleep, only wake frames, bar one write frame probing
        for (int i = 1; i <= edges; i++) begin
            mosi = (i <= 8) ? op[8 - i] : i[0]; // opcode msb first, then dummy
            #6 spi_clk = 1'b1;
            if (i > 32) rx = {rx[14:0], miso};
            if (miso_oe_n === 1'b0) seen_drive = 1'b1;
            #6 spi_clk = 1'b0;
        end
        // select rises right after the last counted edge, held high until the next go
        #6 cs_n = 1'b1;
        mosi = ~mosi; // released data line shows no stale value
        ready = 1'b1;
        wait (go == 1'b0);
        ready = 1'b0;
    end
endmodule

// File: testbench/tb_sfpm_power_ctl.sv
// bench for the power mode block: lockout, grants, sleep entry, wake and signature
// assumes sfpm_host_model drives the link and the design's default delays bar the lockout
`timescale 1ns/1ps
module tb_sfpm_power_ctl import sfpm_pkg::*;;
    localparam logic [7:0] OP_SLEEP = 8'hd1;
    localparam logic [7:0] OP_WAKE = 8'hd2;
    localparam logic [7:0] SIG = 8'h5a; // arbitrary value
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'hd3;
    localparam logic [7:0] OP_PROG = 8'hd4;
    localparam logic [7:0] OP_BLOCK_WIPE = 8'hd5;
    localparam logic [7:0] OP_FULL_WIPE = 8'hd6;
    localparam logic [7:0] OP_STATUS_WRITE = 8'hd7;
    localparam int unsigned LOCK_NS = 2000; // short lockout, 40 cycles, so the run stays brief
    localparam int ENTRY = SLEEP_ENTRY_DEF_NS / CLK_NS;
    localparam int WAKE_C = WAKE_DEF_NS / CLK_NS;
    localparam int EARLY_C = EARLY_WAKE_DEF_NS / CLK_NS;
    typedef struct packed {
        logic [7:0] op;
        logic [5:0] n;
        logic gw;
        logic gr;
    } sfpm_row_s;
    sfpm_row_s rows [7] = '{'{8'hd3, 6'h08, 1'b1, 1'b0}, '{8'hd4, 6'h08, 1'b1, 1'b0},
        '{8'hd5, 6'h08, 1'b1, 1'b0}, '{8'hd6, 6'h08, 1'b1, 1'b0},
        '{8'hd7, 6'h08, 1'b1, 1'b0}, '{8'h03, 6'h20, 1'b0, 1'b1}, '{8'h05, 6'h10, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic busy_in = 1'b0;
    logic write_latch_in = 1'b0;
    logic go = 1'b0;
    logic [7:0] op = 8'h00;
    logic [5:0] edges = 6'h00;
    logic ready, cs_n, spi_clk, mosi, miso_out, miso_oe_n, seen_drive, miso_line;
    logic deep_sleep, standby, write_cmd_grant, read_cmd_grant, gw, gr;
    logic miso_hold = 1'b0;
    logic [15:0] rx;
    logic [7:0] status_byte, erased_byte;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    sfpm_power_ctl #(.LOCKOUT_NS(LOCK_NS), .OP_SLEEP(OP_SLEEP), .OP_WAKE(OP_WAKE),
        .OP_WRITE_ENABLE_CMD(OP_WRITE_ENABLE_CMD), .OP_PROG(OP_PROG), .OP_BLOCK_WIPE(OP_BLOCK_WIPE),
        .OP_FULL_WIPE(OP_FULL_WIPE), .OP_STATUS_WRITE(OP_STATUS_WRITE), .SIGNATURE(SIG))
        sfpm_power_ctl_i (.clk(clk), .nrst(nrst),
        .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n), .busy_in(busy_in), .write_latch_in(write_latch_in),
        .deep_sleep(deep_sleep), .standby(standby), .write_cmd_grant(write_cmd_grant),
        .read_cmd_grant(read_cmd_grant), .status_byte(status_byte), .erased_byte(erased_byte));
    sfpm_host_model sfpm_host_model_i (.go(go), .op(op), .edges(edges), .ready(ready),
        .cs_n(cs_n), .spi_clk(spi_clk), .mosi(mosi), .miso(miso_line),
        .miso_oe_n(miso_oe_n), .rx(rx), .seen_drive(seen_drive));

    // undriven data line shows the inverse of its last value, never a lucky match
    assign miso_line = miso_oe_n ? ~miso_hold : miso_out;
    always @(miso_out or miso_oe_n) begin
        if (miso_oe_n === 1'b0) miso_hold = miso_out;
    end

    always #25 clk = ~clk;

    // hang guard, far above the fewer than a thousand cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one frame, then collect grant pulses over the decode window
    task automatic frame(input logic [7:0] o, input logic [5:0] n);
        int k;
        @(negedge clk);
        op = o;
        edges = n;
        go = 1'b1;
        k = 0;
        while (ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        go = 1'b0;
        gw = 1'b0;
        gr = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            gw = gw | write_cmd_grant;
            gr = gr | read_cmd_grant;
        end
    endtask

    // deep_sleep must reach v inside a window counted from the end of the grant window that frame() waits out after the frame
    task automatic wait_ds(input logic v, input int lo, input int hi);
        int k;
        k = 0;
        while (deep_sleep !== v && k <= hi) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk({15'h0000, k >= lo && k <= hi}, 16'h0001);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        chk({deep_sleep, standby, status_byte}, 16'h0000);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'h00, deep_sleep, standby, status_byte}, {6'h00, 2'b01, 8'h00});
        chk({8'h00, erased_byte}, {8'h00, MEM_ERASED});
        // still inside the write lockout: writes dropped, reads taken
        frame(OP_WRITE_ENABLE_CMD, 6'h08);
        chk({14'h0000, gw, gr}, 16'h0000);
        frame(8'h03, 6'h20);
        chk({14'h0000, gw, gr}, 16'h0001);
        $display("test lockout done");
        repeat (40) @(negedge clk);
        foreach (rows[i]) begin
            frame(rows[i].op, rows[i].n);
            chk({14'h0000, gw, gr}, {14'h0000, rows[i].gw, rows[i].gr});
        end
        $display("test grant rows done");
        // busy engine: status follows, sleep refused and no signature driven on a wake frame
        @(negedge clk);
        busy_in = 1'b1;
        write_latch_in = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, standby, status_byte}, 16'h0003);
        frame(OP_SLEEP, 6'h08);
        repeat (80) @(negedge clk);
        chk({15'h0000, deep_sleep}, 16'h0000);
        frame(OP_WAKE, 6'h28);
        chk({15'h0000, seen_drive}, 16'h0000);
        // inputs change on the falling edge, never just after a rising one
        @(negedge clk);
        busy_in = 1'b0;
        write_latch_in = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h00, standby, status_byte}, 16'h0100);
        $display("test busy done");
        // wrong bit counts never put the device to sleep
        for (int n = 7; n <= 9; n += 2) begin
            frame(OP_SLEEP, n[5:0]);
            repeat (80) @(negedge clk);
            chk({15'h0000, deep_sleep}, 16'h0000);
        end
        frame(OP_SLEEP, 6'h08);
        wait_ds(1'b1, ENTRY - 10, ENTRY + 2);
        frame(OP_WRITE_ENABLE_CMD, 6'h08);
        chk({14'h0000, gw, gr}, 16'h0000);
        frame(OP_WAKE, 6'h30);
        chk(rx, {SIG, SIG});
        wait_ds(1'b0, WAKE_C - 10, WAKE_C + 2);
        repeat (2) @(negedge clk);
        chk({15'h0000, standby}, 16'h0001);
        frame(OP_WAKE, 6'h28);
        chk({6'h00, deep_sleep, standby, rx[7:0]}, {8'h01, SIG});
        $display("test sleep and wake done");
        frame(OP_SLEEP, 6'h08);
        wait_ds(1'b1, ENTRY - 10, ENTRY + 2);
        frame(OP_WAKE, 6'h10);
        wait_ds(1'b0, EARLY_C - 10, EARLY_C + 2);
        $display("test early wake done");
        // supply loss while asleep
        frame(OP_SLEEP, 6'h08);
        wait_ds(1'b1, ENTRY - 10, ENTRY + 2);
        @(negedge clk);
        nrst = 1'b0;
        frame(8'h03, 6'h20);
        chk({14'h0000, gw, gr}, 16'h0000);
        chk({15'h0000, deep_sleep}, 16'h0000);
        @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        chk({14'h0000, deep_sleep, standby}, 16'h0001);
        $display("test second reset done");
        finish_test();
    end
endmodule
